// >>> core/ecfc_regs.svh
// constants for the event counter bank with filtering and cascading
`ifndef ECFC_REGS_SVH
`define ECFC_REGS_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define ECFC_NUM_CNT     18
`define ECFC_CNT_W       40
`define ECFC_EVT_W       4
`define ECFC_IDX_W       5
`define ECFC_BLK_SIZE    4
`define ECFC_FOURTH_BASE 12
`define ECFC_EXT_REGS    6
`define ECFC_EXT_BIT_POS 11

// ----------------------------------------
// fourth block counters
// ----------------------------------------
`define ECFC_C12 5'h0_c
`define ECFC_C14 5'h0_e
`define ECFC_C15 5'h0_f
`define ECFC_C16 5'h1_0
`define ECFC_C17 5'h1_1

// ----------------------------------------
// reset values
// ----------------------------------------
`define ECFC_CNT_RST  40'h00_0000_0000
`define ECFC_FLAG_RST 1'b0

`endif

// >>> core/ecfc_pkg.sv
// types shared by the event counter bank
package ecfc_pkg;
    `include "ecfc_regs.svh"

    typedef logic [`ECFC_CNT_W-1:0] ecfc_cnt_t;
    typedef logic [`ECFC_EVT_W-1:0] ecfc_evt_t;
    typedef logic [`ECFC_IDX_W-1:0] ecfc_idx_t;

    typedef enum logic [1:0] {
        ECFC_IDLE  = 2'b00,
        ECFC_RUN   = 2'b01,
        ECFC_CHAIN = 2'b10
    } ecfc_run_e;
endpackage

// >>> core/ecfc_cnt_if.sv
// link between the bank controller and one counter
`timescale 1ns/1ps
`default_nettype none
interface ecfc_cnt_if;
    import ecfc_pkg::*;
    logic      active;
    logic      compare;
    logic      complement;
    logic      edge_en;
    ecfc_evt_t threshold;
    ecfc_evt_t evt;
    logic      load;
    ecfc_cnt_t load_data;
    ecfc_cnt_t count;
    logic      wrap;

    modport ctl (output active, compare, complement, edge_en, threshold, evt, load, load_data,
                 input count, wrap);
    modport cnt (input active, compare, complement, edge_en, threshold, evt, load, load_data,
                 output count, wrap);
endinterface
`default_nettype wire

// >>> core/ecfc_counter.sv
// one counter: threshold and edge filter, adder, wrap detect
`timescale 1ns/1ps
`default_nettype none
`include "ecfc_regs.svh"

module ecfc_counter (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // controller link
    ecfc_cnt_if.cnt  lnk
);
    import ecfc_pkg::*;

    ecfc_cnt_t            count_r;
    logic                 hit_prev_r;
    logic                 hit;
    ecfc_evt_t            inc;
    logic [`ECFC_CNT_W:0] sum;

    // ----------------------------------------
    // filter
    // ----------------------------------------
    always_comb begin
        hit = lnk.complement ? (lnk.evt <= lnk.threshold)
                             : (lnk.evt > lnk.threshold);
        if (!lnk.compare) begin
            inc = lnk.evt;
        end else if (lnk.edge_en) begin
            inc = {3'b000, hit & ~hit_prev_r};
        end else begin
            inc = {3'b000, hit};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hit_prev_r <= 1'b0;
        end else begin
            hit_prev_r <= hit;
        end
    end

    // ----------------------------------------
    // count
    // ----------------------------------------
    assign sum      = {1'b0, count_r} + {{(`ECFC_CNT_W+1-`ECFC_EVT_W){1'b0}}, inc};
    assign lnk.wrap = lnk.active & ~lnk.load & sum[`ECFC_CNT_W];

    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= `ECFC_CNT_RST;
        end else if (lnk.load) begin
            count_r <= lnk.load_data;
        end else if (lnk.active) begin
            count_r <= sum[`ECFC_CNT_W-1:0];
        end
    end

    assign lnk.count = count_r;
endmodule
`default_nettype wire

// >>> core/ecfc_top.sv
// bank of eighteen event counters with cascade control
`timescale 1ns/1ps
`default_nettype none
`include "ecfc_regs.svh"

module ecfc_top (
    // clock and reset
    input  wire logic                                        clk,
    input  wire logic                                        rst,
    // event inputs, one 4-bit value per counter
    input  wire logic [`ECFC_NUM_CNT-1:0][`ECFC_EVT_W-1:0]   evt_in,
    // per-counter configuration
    input  wire logic [`ECFC_NUM_CNT-1:0]                    cfg_enable,
    input  wire logic [`ECFC_NUM_CNT-1:0]                    cfg_cascade,
    input  wire logic [`ECFC_NUM_CNT-1:0]                    cfg_compare,
    input  wire logic [`ECFC_NUM_CNT-1:0]                    cfg_complement,
    input  wire logic [`ECFC_NUM_CNT-1:0]                    cfg_edge,
    input  wire logic [`ECFC_NUM_CNT-1:0][`ECFC_EVT_W-1:0]   cfg_threshold,
    // fourth block extended chain bits, index is register number
    input  wire logic [`ECFC_EXT_REGS-1:0]                   ext_chain_bits,
    // count preset and flag clear
    input  wire logic [`ECFC_NUM_CNT-1:0]                    cnt_wr,
    input  wire ecfc_pkg::ecfc_cnt_t                         cnt_wr_data,
    input  wire logic [`ECFC_NUM_CNT-1:0]                    wrap_flag_clr,
    // status
    output logic      [`ECFC_NUM_CNT-1:0][`ECFC_CNT_W-1:0]   count_q,
    output logic      [`ECFC_NUM_CNT-1:0]                    sticky_wrap_flag,
    output logic      [`ECFC_NUM_CNT-1:0]                    counting
);
    import ecfc_pkg::*;

    // ----------------------------------------
    // topology functions
    // ----------------------------------------
    // ordinary cascade source: other pair, same block
    function automatic ecfc_idx_t casc_src(input int i);
        ecfc_idx_t r;
        r = 5'h1_f;
        case (i)
            0:       r = 5'h0_2;
            1:       r = 5'h0_3;
            2:       r = 5'h0_0;
            3:       r = 5'h0_1;
            4:       r = 5'h0_6;
            5:       r = 5'h0_7;
            6:       r = 5'h0_4;
            7:       r = 5'h0_5;
            8:       r = 5'h0_a;
            9:       r = 5'h0_b;
            10:      r = 5'h0_8;
            11:      r = 5'h0_9;
            12:      r = `ECFC_C14;
            13:      r = `ECFC_C15;
            14:      r = `ECFC_C12;
            15:      r = 5'h0_d;
            16:      r = `ECFC_C14;
            17:      r = `ECFC_C15;
            default: r = 5'h1_f;
        endcase
        return r;
    endfunction

    // extended cascade source, only for registers 0, 3, 4, 5
    function automatic ecfc_idx_t ext_src(input int i);
        ecfc_idx_t r;
        r = 5'h1_f;
        case (i)
            12:      r = `ECFC_C16;
            15:      r = `ECFC_C17;
            16:      r = `ECFC_C17;
            17:      r = `ECFC_C16;
            default: r = 5'h1_f;
        endcase
        return r;
    endfunction

    function automatic logic src_ok(input ecfc_idx_t s);
        return s < ecfc_idx_t'(`ECFC_NUM_CNT);
    endfunction

    // ----------------------------------------
    // shared state
    // ----------------------------------------
    logic [`ECFC_NUM_CNT-1:0] wrap;
    logic [`ECFC_NUM_CNT-1:0] flag_r;
    logic [`ECFC_NUM_CNT-1:0] flag_nxt;
    logic [`ECFC_NUM_CNT-1:0] flag_live;
    logic [`ECFC_NUM_CNT-1:0] ext_en;
    logic [`ECFC_NUM_CNT-1:0] start;
    logic [`ECFC_NUM_CNT-1:0] hold;
    logic [`ECFC_NUM_CNT-1:0] chained;
    logic [`ECFC_NUM_CNT-1:0] active;
    ecfc_run_e                st_r   [`ECFC_NUM_CNT];
    ecfc_run_e                st_nxt [`ECFC_NUM_CNT];

    // ----------------------------------------
    // extended chain enables
    // ----------------------------------------
    // extended bit per counter, reserved registers 1 and 2 ignored
    always_comb begin
        ext_en = '0;
        for (int i = `ECFC_FOURTH_BASE; i < `ECFC_NUM_CNT; i++) begin
            ext_en[i] = ext_chain_bits[i - `ECFC_FOURTH_BASE] & src_ok(ext_src(i));
        end
    end

    // ----------------------------------------
    // sticky wrap flags
    // ----------------------------------------
    // wrap in the clearing cycle wins over the clear
    always_comb begin
        flag_nxt = flag_r;
        for (int i = 0; i < `ECFC_NUM_CNT; i++) begin
            if (wrap[i]) begin
                flag_nxt[i] = 1'b1;
            end else if (wrap_flag_clr[i]) begin
                flag_nxt[i] = 1'b0;
            end else begin
                flag_nxt[i] = flag_r[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= {`ECFC_NUM_CNT{`ECFC_FLAG_RST}};
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // a clear in progress drops the flag for chain holding this cycle
    assign flag_live        = flag_r & ~wrap_flag_clr;
    assign sticky_wrap_flag = flag_r;

    // ----------------------------------------
    // chain start and hold
    // ----------------------------------------
    // ordinary and extended sources may both arm one counter
    always_comb begin
        start = '0;
        hold  = '0;
        for (int i = 0; i < `ECFC_NUM_CNT; i++) begin
            if (src_ok(casc_src(i)) && cfg_cascade[i]) begin
                start[i] = wrap[casc_src(i)];
                hold[i]  = flag_live[casc_src(i)];
            end
            if (ext_en[i]) begin
                start[i] = start[i] | wrap[ext_src(i)];
                hold[i]  = hold[i] | flag_live[ext_src(i)];
            end
        end
    end

    // ----------------------------------------
    // run state per counter
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < `ECFC_NUM_CNT; i++) begin
            st_nxt[i] = st_r[i];
            case (st_r[i])
                ECFC_IDLE: begin
                    if (cfg_enable[i]) begin
                        st_nxt[i] = ECFC_RUN;
                    end else if (start[i]) begin
                        st_nxt[i] = ECFC_CHAIN;
                    end
                end
                ECFC_RUN: begin
                    if (!cfg_enable[i]) begin
                        st_nxt[i] = ECFC_IDLE;
                    end
                end
                ECFC_CHAIN: begin
                    if (cfg_enable[i]) begin
                        st_nxt[i] = ECFC_RUN;
                    end else if (!hold[i]) begin
                        st_nxt[i] = ECFC_IDLE;
                    end
                end
                default: begin
                    st_nxt[i] = ECFC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < `ECFC_NUM_CNT; i++) begin
            if (rst) begin
                st_r[i] <= ECFC_IDLE;
            end else begin
                st_r[i] <= st_nxt[i];
            end
        end
    end

    // ----------------------------------------
    // counting qualifier
    // ----------------------------------------
    // a chain counts only while its hold stands
    always_comb begin
        for (int i = 0; i < `ECFC_NUM_CNT; i++) begin
            chained[i] = (st_r[i] == ECFC_CHAIN) & hold[i];
        end
    end

    assign active   = cfg_enable | chained;
    assign counting = active;

    // ----------------------------------------
    // counters
    // ----------------------------------------
    for (genvar g = 0; g < `ECFC_NUM_CNT; g++) begin : g_cnt
        ecfc_cnt_if lnk ();

        assign lnk.active     = active[g];
        assign lnk.compare    = cfg_compare[g];
        assign lnk.complement = cfg_complement[g];
        assign lnk.edge_en    = cfg_edge[g];
        assign lnk.threshold  = cfg_threshold[g];
        assign lnk.evt        = evt_in[g];
        assign lnk.load       = cnt_wr[g];
        assign lnk.load_data  = cnt_wr_data;

        ecfc_counter u_cnt (
            .clk (clk),
            .rst (rst),
            .lnk (lnk.cnt)
        );

        assign wrap[g]    = lnk.wrap;
        assign count_q[g] = lnk.count;
    end
endmodule
`default_nettype wire

// >>> testbench/ecfc_top_sva.sv
// assertion checker for the event counter bank
`timescale 1ns/1ps
`default_nettype none
module ecfc_top_sva (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // inputs
    input wire logic [17:0][3:0]  evt_in,
    input wire logic [17:0]       cfg_enable,
    input wire logic [17:0]       cfg_cascade,
    input wire logic [17:0]       cfg_compare,
    input wire logic [17:0]       cfg_complement,
    input wire logic [17:0]       cfg_edge,
    input wire logic [17:0][3:0]  cfg_threshold,
    input wire logic [17:0]       cnt_wr,
    input wire logic [17:0]       wrap_flag_clr,
    // status
    input wire logic [17:0][39:0] count_q,
    input wire logic [17:0]       sticky_wrap_flag,
    input wire logic [17:0]       counting
);
    // ----------------------------------------
    // helpers for counter 0
    // ----------------------------------------
    logic        hit0;
    logic        wrap0;
    logic [40:0] sum0;
    assign hit0  = cfg_complement[0] ? (evt_in[0] <= cfg_threshold[0]) : (evt_in[0] > cfg_threshold[0]);
    assign sum0  = {1'b0, count_q[0]} + {37'h0, evt_in[0]};
    assign wrap0 = counting[0] & ~cnt_wr[0] & ~cfg_compare[0] & sum0[40];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_arm;
        wrap0 && cfg_cascade[2] && !cfg_enable[2];
    endsequence
    property p_raw_add;
        counting[0] && !cnt_wr[0] && !cfg_compare[0] |=> count_q[0] == $past(count_q[0]) + $past(evt_in[0]);
    endproperty
    property p_thr_add;
        counting[0] && !cnt_wr[0] && cfg_compare[0] && !cfg_edge[0] |=> count_q[0] == $past(count_q[0]) + $past(hit0);
    endproperty
    property p_edge_add;
        counting[0] && !cnt_wr[0] && cfg_compare[0] && cfg_edge[0]
        |=> count_q[0] == $past(count_q[0]) + ($past(hit0) & ~$past(hit0, 2));
    endproperty
    property p_en_runs;
        cfg_enable[0] |-> counting[0];
    endproperty
    property p_hold;
        !counting[0] && !cnt_wr[0] |=> $stable(count_q[0]);
    endproperty
    property p_wrap_set;
        wrap0 |=> sticky_wrap_flag[0];
    endproperty
    property p_sticky;
        sticky_wrap_flag[0] && !wrap_flag_clr[0] |=> sticky_wrap_flag[0];
    endproperty
    property p_clr;
        wrap_flag_clr[0] && !wrap0 |=> !sticky_wrap_flag[0];
    endproperty
    property p_chain;
        s_arm ##1 (cfg_cascade[2] && !wrap_flag_clr[0]) |-> counting[2];
    endproperty
    property p_idle_wait;
        !counting[2] && !cfg_enable[2] && !cfg_compare[0] && !wrap0 |=> cfg_enable[2] || !counting[2];
    endproperty
    property p_chain_stop;
        wrap_flag_clr[0] && !cfg_enable[2] |-> !counting[2];
    endproperty
    property p_off_idle;
        !cfg_enable[2] && !cfg_cascade[2] |-> !counting[2];
    endproperty
    a_raw_add: assert property (p_raw_add) else $error("raw add wrong");
    a_thr_add: assert property (p_thr_add) else $error("threshold add wrong");
    a_edge_add: assert property (p_edge_add) else $error("edge add wrong");
    a_en_runs: assert property (p_en_runs) else $error("enabled counter idle");
    a_hold: assert property (p_hold) else $error("idle count moved");
    a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not set");
    a_sticky: assert property (p_sticky) else $error("wrap flag lost");
    a_clr: assert property (p_clr) else $error("wrap flag not cleared");
    a_chain: assert property (p_chain) else $error("chain did not start");
    a_idle_wait: assert property (p_idle_wait) else $error("chain started early");
    a_chain_stop: assert property (p_chain_stop) else $error("chain not stopped");
    a_off_idle: assert property (p_off_idle) else $error("unarmed counter runs");
endmodule
`default_nettype wire

// >>> testbench/ecfc_evt_src.sv
// event source model feeding the counter inputs
`timescale 1ns/1ps
`default_nettype none
module ecfc_evt_src (
    // requested event values
    input  wire logic [17:0][3:0] evt_set,
    // event lines to the counters
    output logic      [17:0][3:0] evt_in
);
    // ----------------------------------------
    // level event lines, held between changes
    // ----------------------------------------
    assign evt_in = evt_set;
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the event counter bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ecfc_pkg::*;
    // ----------------------------------------
    // stimulus and status
    // ----------------------------------------
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [17:0][3:0]  evt_set = '0;
    logic [17:0][3:0]  thr = '0;
    logic [17:0][3:0]  evt_in;
    logic [17:0]       en = '0, casc = '0, cmp = '0, cpl = '0, edg = '0, wr = '0, clr = '0;
    logic [5:0]        ext = '0;
    ecfc_cnt_t         wdata = '1;
    logic [17:0][39:0] cnt;
    logic [17:0]       flg;
    logic [17:0]       run;
    int                n_fail = 0;
    int                checked = 0;
    int                src_t [15] = '{16, 16, 17, 14, 15, 16, 17, 17, 16, 0, 2, 1, 4, 0, 0};
    int                dst_t [15] = '{12, 14, 15, 16, 17, 12, 15, 16, 17, 2, 0, 3, 6, 1, 4};
    logic [5:0]        ext_t [15] = '{6'h06, 0, 0, 0, 0, 6'h01, 6'h08, 6'h10, 6'h20, 0, 0, 0, 0, 0, 0};
    logic [14:0]       casc_t = 15'h7e1f;
    logic [14:0]       exp_t = 15'h1ff8;
    always #12.5 clk = ~clk;
    ecfc_evt_src u_src (.evt_set(evt_set), .evt_in(evt_in));
    ecfc_top DUT (.clk(clk), .rst(rst), .evt_in(evt_in), .cfg_enable(en), .cfg_cascade(casc), .cfg_compare(cmp),
        .cfg_complement(cpl), .cfg_edge(edg), .cfg_threshold(thr), .ext_chain_bits(ext), .cnt_wr(wr),
        .cnt_wr_data(wdata), .wrap_flag_clr(clr), .count_q(cnt), .sticky_wrap_flag(flg), .counting(run));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string nm, input ecfc_cnt_t exp, input ecfc_cnt_t got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic restart();
        rst = 1'b1;
        {en, casc, cmp, cpl, edg, wr, clr, ext, thr, evt_set} = '0;
        step(1);
        rst = 1'b0;
    endtask
    task automatic run_chain(input int s, input int d, input logic [5:0] e, input logic c, input int x);
        restart();
        ext = e;
        casc[d] = c;
        evt_set = {18{4'h1}};
        wr[s] = 1'b1;
        step(1);
        wr[s] = 1'b0;
        en[s] = 1'b1;
        step(3);
        check("chain count", ecfc_cnt_t'(x), cnt[d]);
        check("source count", 40'h00_0000_0002, cnt[s]);
        check("wrap flag", 40'h00_0000_0001, ecfc_cnt_t'(flg[s]));
    endtask
    task automatic complete_run();
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // sequence and watchdog
    // ----------------------------------------
    initial begin
        step(8);
        rst = 1'b0;
        en[0] = 1'b1;
        evt_set[0] = 4'hf;
        step(3);
        check("raw count", 40'h00_0000_002d, cnt[0]);
        en[0] = 1'b0;
        step(4);
        check("halted count", 40'h00_0000_002d, cnt[0]);
        for (int c = 0; c < 2; c++) begin
            restart();
            {cmp[0], cpl[0], en[0], thr[0]} = {1'b1, c[0], 1'b1, 4'h6};
            for (int v = 0; v < 16; v++) begin
                evt_set[0] = v[3:0];
                step(1);
            end
            check("threshold count", ecfc_cnt_t'(c ? 7 : 9), cnt[0]);
        end
        restart();
        {cmp[0], edg[0], en[0], thr[0]} = {3'b111, 4'h6};
        foreach (exp_t[v]) begin
            if (v < 5) begin
                evt_set[0] = (v == 2) ? 4'h0 : ((v < 2) ? 4'h7 : 4'h9);
                step(1);
            end
        end
        check("edge count", 40'h00_0000_0002, cnt[0]);
        cmp[0] = 1'b0;
        evt_set[0] = 4'h3;
        step(2);
        check("edge without compare", 40'h00_0000_0008, cnt[0]);
        for (int i = 0; i < 15; i++) begin
            run_chain(src_t[i], dst_t[i], ext_t[i], casc_t[i], exp_t[i] ? 2 : 0);
        end
        run_chain(0, 2, 6'h00, 1'b1, 2);
        clr[0] = 1'b1;
        step(1);
        clr[0] = 1'b0;
        step(2);
        check("stopped chain", 40'h00_0000_0002, cnt[2]);
        check("cleared flag", 40'h00_0000_0000, ecfc_cnt_t'(flg[0]));
        check("enabled source", 40'h00_0000_0005, cnt[0]);
        run_chain(0, 2, 6'h00, 1'b1, 2);
        casc[2] = 1'b0;
        step(2);
        check("unchained count", 40'h00_0000_0002, cnt[2]);
        complete_run();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule
bind ecfc_top ecfc_top_sva u_sva (.clk(clk), .rst(rst), .evt_in(evt_in), .cfg_enable(cfg_enable),
    .cfg_cascade(cfg_cascade), .cfg_compare(cfg_compare), .cfg_complement(cfg_complement), .cfg_edge(cfg_edge),
    .cfg_threshold(cfg_threshold), .cnt_wr(cnt_wr), .wrap_flag_clr(wrap_flag_clr), .count_q(count_q),
    .sticky_wrap_flag(sticky_wrap_flag), .counting(counting));
`default_nettype wire
